// File: fault_status_regs.vh
// command codes, bit positions and reset values of the fault status registers
`ifndef FAULT_STATUS_REGS_VH
`define FAULT_STATUS_REGS_VH

// command codes on the management port
`define CMD_FAULT_SUMMARY_WORD 8'h79
`define CMD_OUTPUT_VOLTAGE_FLAGS 8'h7A

// special values written to the summary word
`define WORD_CLEAR_BUSY 16'h0080
`define WORD_CLEAR_BUSY_UNKNOWN 16'h0180

// summary word bit positions
`define SUM_OUTPUT_VOLTAGE_BIT 15
`define SUM_OUTPUT_CURRENT_BIT 14
`define SUM_INPUT_BIT 13
`define SUM_MAKER_DEFINED_BIT 12
`define SUM_POWER_GOOD_BIT 11
`define SUM_RSVD_HI_BIT 10
`define SUM_OTHER_BIT 9
`define SUM_RSVD_LO_BIT 8

// summary byte (low byte of the word) bit positions
`define BYTE_BUSY_BIT 7
`define BYTE_OFF_BIT 6
`define BYTE_OV_BIT 5
`define BYTE_OC_BIT 4
`define BYTE_INPUT_UV_BIT 3
`define BYTE_TEMP_BIT 2
`define BYTE_COMM_BIT 1
`define BYTE_UNKNOWN_BIT 0

// output voltage flag bit positions
`define OVF_OV_FAULT_BIT 7
`define OVF_OV_WARN_BIT 6
`define OVF_UV_WARN_BIT 5
`define OVF_UV_FAULT_BIT 4
`define OVF_LIMIT_BIT 3
`define OVF_TURN_ON_BIT 2

// supported latched flags of the output voltage register, bits 1:0 read zero
`define OVF_SUPPORTED_MASK 8'hFC

// reset values
`define OVF_RESET 8'h00
`define WORD_RESET 16'h0000
`define ZERO_BYTE 8'h00

`endif

// File: pin_sync.v
// three-stage pin synchroniser with agreement filter, one lane per bit
module pin_sync #(
   parameter WIDTH = 1
) (
   input wire clock,                  // system clock
   input wire rst_b,                  // synchronous reset, active low
   input wire [WIDTH-1:0] pin_in,     // raw asynchronous pin levels
   output wire [WIDTH-1:0] level_out  // filtered level, from a flip-flop
);

   genvar i;

   // one synchroniser lane for each pin
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : lane
         reg s1_ff;     // first stage, read only by the second
         reg s2_ff;     // second stage
         reg s3_ff;     // third stage
         reg level_ff;  // accepted level

         // shift the pin through three stages, accept when stages two and three agree
         always @(posedge clock) begin
            if (!rst_b) begin
               s1_ff <= 1'b0;
               s2_ff <= 1'b0;
               s3_ff <= 1'b0;
               level_ff <= 1'b0;
            end else begin
               s1_ff <= pin_in[i];
               s2_ff <= s1_ff;
               s3_ff <= s2_ff;
               if (s2_ff == s3_ff) begin
                  level_ff <= s3_ff;
               end
            end
         end

         assign level_out[i] = level_ff;
      end
   endgenerate

endmodule // pin_sync

// File: fault_status_summary_regs.v
// fault summary word and output voltage flag registers behind the management command port
`include "fault_status_regs.vh"

// What this block does
// - summary word read and written at 79h
// - word low byte is the summary byte storage
// - bit 15 flags an output voltage fault
// - bit 14 flags an output current fault
// - bit 13 flags an input fault
// - bit 12 flags a maker-defined fault
// - bit 11 live power-good, one when outside
// - bit 9 flags an other-category fault
// - word bits 10 and 8 read zero
// - writing 0080h clears the busy flag
// - writing 0180h clears busy and unknown flags
// - every alerting bit has its own mask
// - voltage flags at 7Ah, byte access, unphased
// - voltage flags clear by clear-all or one-write
// - bit 7 latches overvoltage fault, extended mask
// - bit 6 latches overvoltage warning
// - bit 5 latches undervoltage warning
// - bit 4 latches undervoltage fault
// - bit 3 latches output limit violation
// - bit 2 latches turn-on timeout
// - voltage flag bits 1:0 read zero
// - summary bits follow detailed flags, except live bits 11 and 6 and the busy and unknown flags
module fault_status_summary_regs (
   input wire clock,                       // system clock, 125 MHz
   input wire rst_b,                       // synchronous reset, active low
   input wire [7:0] cmd_code,              // command code of the current transaction
   input wire wr_stb,                      // one-cycle write strobe
   input wire [15:0] wr_data,              // write data, byte commands use bits 7:0
   input wire rd_stb,                      // one-cycle read strobe
   input wire clear_faults_stb,            // one-cycle clear-all-faults request
   input wire ov_fixed_pin,                // fixed overvoltage detector, async
   input wire ov_tracking_pin,             // tracking overvoltage detector, async
   input wire ov_prebias_pin,              // prebiased overvoltage detector, async
   input wire ov_warn_pin,                 // overvoltage warning detector, async
   input wire uv_warn_pin,                 // undervoltage warning detector, async
   input wire uv_fault_pin,                // undervoltage fault detector, async
   input wire limit_violation_pin,         // commanded voltage outside limits, async
   input wire turn_on_timeout_pin,         // turn-on time exceeded, async
   input wire power_good_live_pin,         // high while output outside regulation, async
   input wire converter_off_pin,           // high while not converting power, async
   input wire busy_evt,                    // one-cycle busy-declared event
   input wire unknown_evt,                 // one-cycle unlisted-fault event
   input wire output_current_summary,      // current detail register has a flag set
   input wire input_summary,               // input detail register has a flag set
   input wire maker_defined_summary,       // maker detail register has a flag set
   input wire other_summary,               // other detail register has a flag set
   input wire overcurrent_summary,         // output overcurrent fault latched elsewhere
   input wire input_uv_summary,            // input undervoltage fault latched elsewhere
   input wire temp_summary,                // temperature flag latched elsewhere
   input wire comm_summary,                // communication flag latched elsewhere
   input wire [7:0] voltage_alert_mask,    // alert mask per output voltage flag
   input wire [2:0] extended_alert_mask,   // separate masks for fixed, tracking, prebias
   input wire [1:0] byte_alert_mask,       // alert mask: bit 1 busy, bit 0 unknown
   output reg [15:0] rd_data_ff,           // read data, valid with rd_valid_ff
   output reg rd_valid_ff,                 // one-cycle read answer
   output reg cmd_unsupported_ff,          // one-cycle pulse on an unmapped command
   output reg alert_req_ff,                // level: an unmasked alerting flag is set
   output reg [15:0] fault_summary_word_ff // live copy of the summary word
);

   // set wins over clear for every latched flag
   function [7:0] flag_next;
      input [7:0] cur;    // current flag bits
      input [7:0] setv;   // bits being set this cycle
      input [7:0] clrv;   // bits being cleared this cycle
      begin
         flag_next = (cur & ~clrv) | setv;
      end
   endfunction

   // command decode, used by read and write paths
   function is_cmd;
      input [7:0] code;    // command on the port
      input [7:0] target;  // command to match
      begin
         is_cmd = (code == target);
      end
   endfunction

   wire [9:0] pin_level;          // synchronised pin levels
   wire ov_fixed_s;               // fixed overvoltage, synchronised
   wire ov_tracking_s;            // tracking overvoltage, synchronised
   wire ov_prebias_s;             // prebiased overvoltage, synchronised
   wire ov_warn_s;                // overvoltage warning, synchronised
   wire uv_warn_s;                // undervoltage warning, synchronised
   wire uv_fault_s;               // undervoltage fault, synchronised
   wire limit_s;                  // limit violation, synchronised
   wire turn_on_s;                // turn-on timeout, synchronised
   wire power_good_s;             // live power-good, synchronised
   wire converter_off_s;          // live off state, synchronised

   reg [7:0] output_voltage_flags_ff;  // latched output voltage flags
   reg [7:0] nxt_output_voltage_flags; // next output voltage flags
   reg [2:0] ov_kind_ff;               // which overvoltage kinds caused bit 7
   reg [2:0] nxt_ov_kind;              // next overvoltage kinds
   reg busy_ff;                        // busy-declared flag
   reg nxt_busy;                       // next busy flag
   reg unknown_ff;                     // unlisted-fault flag
   reg nxt_unknown;                    // next unlisted-fault flag

   reg [7:0] voltage_set;         // voltage flag set terms
   reg [7:0] voltage_clr;         // voltage flag clear terms
   reg [2:0] kind_set;            // overvoltage kind set terms
   reg [7:0] summary_byte;        // assembled summary byte
   reg [15:0] summary_word;       // assembled summary word
   reg alert_now;                 // combined alert request
   reg write_voltage;             // byte write to the voltage flags
   reg write_word;                // word write to the summary word

   // bring every detector pin into the clock domain
   pin_sync #(
      .WIDTH(10)
   ) u_pin_sync (
      .clock(clock),
      .rst_b(rst_b),
      .pin_in({converter_off_pin, power_good_live_pin, turn_on_timeout_pin,
               limit_violation_pin, uv_fault_pin, uv_warn_pin, ov_warn_pin,
               ov_prebias_pin, ov_tracking_pin, ov_fixed_pin}),
      .level_out(pin_level)
   );

   // name the synchronised lanes
   assign ov_fixed_s = pin_level[0];
   assign ov_tracking_s = pin_level[1];
   assign ov_prebias_s = pin_level[2];
   assign ov_warn_s = pin_level[3];
   assign uv_warn_s = pin_level[4];
   assign uv_fault_s = pin_level[5];
   assign limit_s = pin_level[6];
   assign turn_on_s = pin_level[7];
   assign power_good_s = pin_level[8];
   assign converter_off_s = pin_level[9];

   // decode writes from the command port
   always @* begin
      write_voltage = wr_stb && is_cmd(cmd_code, `CMD_OUTPUT_VOLTAGE_FLAGS);
      write_word = wr_stb && is_cmd(cmd_code, `CMD_FAULT_SUMMARY_WORD);
   end

   // set and clear terms of the output voltage flags
   always @* begin
      voltage_set = `ZERO_BYTE;
      voltage_clr = `ZERO_BYTE;
      kind_set = {ov_prebias_s, ov_tracking_s, ov_fixed_s};
      // any overvoltage kind latches the fault flag
      voltage_set[`OVF_OV_FAULT_BIT] = |kind_set;
      voltage_set[`OVF_OV_WARN_BIT] = ov_warn_s;
      voltage_set[`OVF_UV_WARN_BIT] = uv_warn_s;
      voltage_set[`OVF_UV_FAULT_BIT] = uv_fault_s;
      voltage_set[`OVF_LIMIT_BIT] = limit_s;
      voltage_set[`OVF_TURN_ON_BIT] = turn_on_s;
      if (clear_faults_stb) begin
         // clear-all drops every supported flag
         voltage_clr = `OVF_SUPPORTED_MASK;
      end else if (write_voltage) begin
         // write one clears, write zero leaves the flag alone
         voltage_clr = wr_data[7:0] & `OVF_SUPPORTED_MASK;
      end
   end

   // next state of all latched flags
   always @* begin
      // unsupported bits 1:0 never hold a one
      nxt_output_voltage_flags = flag_next(output_voltage_flags_ff, voltage_set, voltage_clr)
                                 & `OVF_SUPPORTED_MASK;
      // kinds are remembered while the fault flag stands
      if (voltage_clr[`OVF_OV_FAULT_BIT]) begin
         nxt_ov_kind = kind_set;
      end else begin
         nxt_ov_kind = ov_kind_ff | kind_set;
      end
      nxt_busy = busy_ff;
      nxt_unknown = unknown_ff;
      if (write_word && (wr_data == `WORD_CLEAR_BUSY)) begin
         nxt_busy = 1'b0;
      end else if (write_word && (wr_data == `WORD_CLEAR_BUSY_UNKNOWN)) begin
         nxt_busy = 1'b0;
         nxt_unknown = 1'b0;
      end else if (clear_faults_stb) begin
         // clear-all also drops the busy and unknown flags of the summary byte, except with a 0080h word write in the same cycle, which clears busy alone
         nxt_busy = 1'b0;
         nxt_unknown = 1'b0;
      end
      // a new event wins over any clear in the same cycle
      if (busy_evt) begin
         nxt_busy = 1'b1;
      end
      if (unknown_evt) begin
         nxt_unknown = 1'b1;
      end
   end

   // assemble the summary byte and word from detailed state
   always @* begin
      summary_byte = `ZERO_BYTE;
      summary_byte[`BYTE_BUSY_BIT] = busy_ff;
      summary_byte[`BYTE_OFF_BIT] = converter_off_s;
      // overvoltage summary follows the detailed fault flag
      summary_byte[`BYTE_OV_BIT] = output_voltage_flags_ff[`OVF_OV_FAULT_BIT];
      summary_byte[`BYTE_OC_BIT] = overcurrent_summary;
      summary_byte[`BYTE_INPUT_UV_BIT] = input_uv_summary;
      summary_byte[`BYTE_TEMP_BIT] = temp_summary;
      summary_byte[`BYTE_COMM_BIT] = comm_summary;
      summary_byte[`BYTE_UNKNOWN_BIT] = unknown_ff;
      summary_word = `WORD_RESET;
      // low byte is the very same storage as the summary byte
      summary_word[7:0] = summary_byte;
      summary_word[`SUM_OUTPUT_VOLTAGE_BIT] = |output_voltage_flags_ff;
      summary_word[`SUM_OUTPUT_CURRENT_BIT] = output_current_summary;
      summary_word[`SUM_INPUT_BIT] = input_summary;
      summary_word[`SUM_MAKER_DEFINED_BIT] = maker_defined_summary;
      summary_word[`SUM_POWER_GOOD_BIT] = power_good_s;
      summary_word[`SUM_OTHER_BIT] = other_summary;
      summary_word[`SUM_RSVD_HI_BIT] = 1'b0;
      summary_word[`SUM_RSVD_LO_BIT] = 1'b0;
   end

   // combine unmasked alerting flags into one request
   always @* begin
      alert_now = 1'b0;
      // bit 7 alerts only for an overvoltage kind not masked by the extended mask
      if (output_voltage_flags_ff[`OVF_OV_FAULT_BIT] && !voltage_alert_mask[`OVF_OV_FAULT_BIT]
          && |(ov_kind_ff & ~extended_alert_mask)) begin
         alert_now = 1'b1;
      end
      // the remaining voltage flags each have their own mask bit
      if (|(output_voltage_flags_ff & ~voltage_alert_mask & 8'h7C)) begin
         alert_now = 1'b1;
      end
      if (busy_ff && !byte_alert_mask[1]) begin
         alert_now = 1'b1;
      end
      if (unknown_ff && !byte_alert_mask[0]) begin
         alert_now = 1'b1;
      end
   end

   // latched flag storage
   always @(posedge clock) begin
      if (!rst_b) begin
         // every latched flag starts clear
         output_voltage_flags_ff <= `OVF_RESET;
         ov_kind_ff <= 3'h0;
         busy_ff <= 1'b0;
         unknown_ff <= 1'b0;
      end else begin
         output_voltage_flags_ff <= nxt_output_voltage_flags;
         ov_kind_ff <= nxt_ov_kind;
         busy_ff <= nxt_busy;
         unknown_ff <= nxt_unknown;
      end
   end

   // command port answers and registered status outputs
   always @(posedge clock) begin
      if (!rst_b) begin
         rd_data_ff <= `WORD_RESET;
         rd_valid_ff <= 1'b0;
         cmd_unsupported_ff <= 1'b0;
         alert_req_ff <= 1'b0;
         fault_summary_word_ff <= `WORD_RESET;
      end else begin
         rd_valid_ff <= 1'b0;
         cmd_unsupported_ff <= 1'b0;
         alert_req_ff <= alert_now;
         fault_summary_word_ff <= summary_word;
         if (wr_stb) begin
            // writes to read-only summary bits change nothing
            if (!write_word && !write_voltage) begin
               cmd_unsupported_ff <= 1'b1;
            end
         end else if (rd_stb) begin
            if (is_cmd(cmd_code, `CMD_FAULT_SUMMARY_WORD)) begin
               // word read returns the whole summary
               rd_data_ff <= summary_word;
               rd_valid_ff <= 1'b1;
            end else if (is_cmd(cmd_code, `CMD_OUTPUT_VOLTAGE_FLAGS)) begin
               // byte read, upper byte zero
               rd_data_ff <= {`ZERO_BYTE, output_voltage_flags_ff};
               rd_valid_ff <= 1'b1;
            end else begin
               // unmapped command: answer zero and flag it
               rd_data_ff <= `WORD_RESET;
               cmd_unsupported_ff <= 1'b1;
            end
         end
      end
   end

endmodule // fault_status_summary_regs

// File: fault_status_asserts.sv
// port-level assertions for the fault status register block
`include "fault_status_regs.vh"
module fault_status_asserts (
   input wire logic clock, // system clock
   input wire logic rst_b, // sync reset, active low
   input wire logic [7:0] cmd_code, // command code
   input wire logic wr_stb, // write strobe
   input wire logic [15:0] wr_data, // write data
   input wire logic rd_stb, // read strobe
   input wire logic power_good_live_pin, // live regulation pin
   input wire logic busy_evt, // busy event pulse
   input wire logic unknown_evt, // unlisted fault pulse
   input wire logic output_current_summary, // current detail summary
   input wire logic [15:0] rd_data_ff, // read data
   input wire logic rd_valid_ff, // read answer pulse
   input wire logic cmd_unsupported_ff, // unmapped command pulse
   input wire logic [15:0] fault_summary_word_ff // live summary word
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   // a read request with nothing competing for the port
   sequence rd_req(logic [7:0] c);
      rd_stb && !wr_stb && cmd_code == c;
   endsequence
   // live pin held long enough to cross the synchroniser
   sequence pg_high_held;
      power_good_live_pin [*8];
   endsequence
   a_word_read_ans: assert property (rd_req(8'h79) |=> rd_valid_ff && !rd_data_ff[10] && !rd_data_ff[8])
      else $error("summary word read answer wrong");
   a_flag_read_ans: assert property (rd_req(8'h7A) |=> rd_valid_ff && rd_data_ff[15:8] == 8'h00 && rd_data_ff[1:0] == 2'h0)
      else $error("voltage flag read answer wrong");
   a_unmapped_read: assert property ((rd_stb && !wr_stb && cmd_code != 8'h79 && cmd_code != 8'h7A) |=> cmd_unsupported_ff && !rd_valid_ff && rd_data_ff == 16'h0000)
      else $error("unmapped read not refused");
   a_valid_cause: assert property (rd_valid_ff |-> $past(rd_stb && !wr_stb))
      else $error("read answer without request");
   a_word_zero_bits: assert property (!fault_summary_word_ff[10] && !fault_summary_word_ff[8])
      else $error("unsupported word bits set");
   a_power_good_live_live: assert property (pg_high_held |-> fault_summary_word_ff[11])
      else $error("live power-good bit missing");
   a_current_sum: assert property (output_current_summary [*3] |-> fault_summary_word_ff[14])
      else $error("current summary bit missing");
   a_busy_unk_clear: assert property ((wr_stb && cmd_code == 8'h79 && wr_data == 16'h0180 && !busy_evt && !unknown_evt) |-> ##2 (fault_summary_word_ff[7] == 1'b0 && fault_summary_word_ff[0] == 1'b0))
      else $error("busy and unknown not cleared");
   a_busy_clear: assert property ((wr_stb && cmd_code == 8'h79 && wr_data == 16'h0080 && !busy_evt) |-> ##2 !fault_summary_word_ff[7])
      else $error("busy not cleared");
endmodule // fault_status_asserts
bind fault_status_summary_regs fault_status_asserts fault_status_asserts_inst (
   .clock(clock), .rst_b(rst_b), .cmd_code(cmd_code), .wr_stb(wr_stb), .wr_data(wr_data),
   .rd_stb(rd_stb), .power_good_live_pin(power_good_live_pin), .busy_evt(busy_evt),
   .unknown_evt(unknown_evt), .output_current_summary(output_current_summary),
   .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .cmd_unsupported_ff(cmd_unsupported_ff),
   .fault_summary_word_ff(fault_summary_word_ff));

// File: pmbus_host_model.sv
// management host model driving the command port of the fault status block
module pmbus_host_model (
   input wire logic clock, // system clock
   output logic [7:0] cmd_code, // command code
   output logic wr_stb, // write strobe
   output logic [15:0] wr_data, // write data
   output logic rd_stb, // read strobe
   output logic clear_faults_stb, // clear-all strobe
   input wire logic [15:0] rd_data_ff, // read data
   input wire logic rd_valid_ff, // read answer pulse
   input wire logic cmd_unsupported_ff // unmapped command pulse
);
   timeunit 1ns;
   timeprecision 100ps;
   // port idles quiet, data bus parked on a non-zero pattern
   initial begin
      cmd_code = 8'h00;
      wr_stb = 1'b0;
      wr_data = 16'hA5A5;
      rd_stb = 1'b0;
      clear_faults_stb = 1'b0;
   end
   // one strobed transfer; the answer is taken one edge after the request
   task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [15:0] data,
         output logic [15:0] q, output logic ok, output logic bad);
      @(posedge clock);
      #1;
      cmd_code = cmd;
      wr_data = data;
      wr_stb = wr;
      rd_stb = !wr;
      @(posedge clock);
      #1;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      wr_data = ~data;
      q = rd_data_ff;
      ok = rd_valid_ff;
      bad = cmd_unsupported_ff;
   endtask
   // clear-all pulse: drops the voltage flags and the busy and unknown flags
   task automatic clear_all();
      @(posedge clock);
      #1;
      clear_faults_stb = 1'b1;
      @(posedge clock);
      #1;
      clear_faults_stb = 1'b0;
   endtask
endmodule // pmbus_host_model

// File: testbench.sv
// self-checking bench for the fault status register block
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock = 1'b0; // system clock
   logic rst_b = 1'b0; // sync reset, active low
   logic [7:0] det; // detector pins: fixed, tracking, prebias, warn, uv warn, uv, limit, ton
   logic [9:0] sumv; // summary inputs and live pins
   logic [7:0] vmask; // voltage alert masks
   logic [2:0] xmask; // extended overvoltage masks
   logic [1:0] bmask; // busy and unknown alert masks
   logic busy_evt; // busy event
   logic unknown_evt; // unlisted fault event
   wire [7:0] cmd_code; // host command
   wire wr_stb, rd_stb, clear_faults_stb; // host strobes
   wire [15:0] wr_data, rd_data_ff, word; // buses
   wire rd_valid_ff, cmd_unsupported_ff, alert_req_ff; // answers
   logic [15:0] q; // read result
   logic ok, bad; // answer flags
   int errors = 0; // mismatches
   int n_checks = 0; // comparisons
   int vbit[8] = '{7, 7, 7, 6, 5, 4, 3, 2}; // flag bit per detector
   int sbit[10] = '{14, 13, 12, 9, 4, 3, 2, 1, 11, 6}; // word bit per summary
   always #4 clock = ~clock;
   fault_status_summary_regs fault_status_summary_regs_inst (.clock(clock), .rst_b(rst_b),
      .cmd_code(cmd_code), .wr_stb(wr_stb), .wr_data(wr_data), .rd_stb(rd_stb),
      .clear_faults_stb(clear_faults_stb), .ov_fixed_pin(det[0]), .ov_tracking_pin(det[1]),
      .ov_prebias_pin(det[2]), .ov_warn_pin(det[3]), .uv_warn_pin(det[4]),
      .uv_fault_pin(det[5]), .limit_violation_pin(det[6]), .turn_on_timeout_pin(det[7]),
      .power_good_live_pin(sumv[8]), .converter_off_pin(sumv[9]), .busy_evt(busy_evt),
      .unknown_evt(unknown_evt), .output_current_summary(sumv[0]), .input_summary(sumv[1]),
      .maker_defined_summary(sumv[2]), .other_summary(sumv[3]), .overcurrent_summary(sumv[4]),
      .input_uv_summary(sumv[5]), .temp_summary(sumv[6]), .comm_summary(sumv[7]),
      .voltage_alert_mask(vmask), .extended_alert_mask(xmask), .byte_alert_mask(bmask),
      .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .cmd_unsupported_ff(cmd_unsupported_ff),
      .alert_req_ff(alert_req_ff), .fault_summary_word_ff(word));
   pmbus_host_model pmbus_host_model_inst (.clock(clock), .cmd_code(cmd_code), .wr_stb(wr_stb),
      .wr_data(wr_data), .rd_stb(rd_stb), .clear_faults_stb(clear_faults_stb),
      .rd_data_ff(rd_data_ff), .rd_valid_ff(rd_valid_ff), .cmd_unsupported_ff(cmd_unsupported_ff));
   // compare one value
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // let n edges pass, then step off the edge
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // mapped read with expected data
   task automatic rd_chk(input logic [7:0] c, input logic [15:0] exp);
      pmbus_host_model_inst.xfer(1'b0, c, 16'h0000, q, ok, bad);
      check({15'h0000, ok}, 16'h0001);
      check(q, exp);
   endtask
   // write, then let flags and the word copy settle
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      pmbus_host_model_inst.xfer(1'b1, c, d, q, ok, bad);
      idle(3);
   endtask
   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      det = 8'h00;
      sumv = 10'h000;
      vmask = 8'h00;
      xmask = 3'h0;
      bmask = 2'h0;
      busy_evt = 1'b0;
      unknown_evt = 1'b0;
      idle(4);
      rst_b = 1'b1;
      idle(2);
      rd_chk(8'h79, 16'h0000);
      rd_chk(8'h7A, 16'h0000);
      end_test("reset");
      for (int i = 0; i < 8; i++) begin
         det[i] = 1'b1;
         idle(10);
         det[i] = 1'b0;
         idle(8);
         rd_chk(8'h7A, 16'h0001 << vbit[i]);
         rd_chk(8'h79, (i < 3) ? 16'h8020 : 16'h8000);
         check({15'h0000, alert_req_ff}, 16'h0001);
         if (i < 3)
            xmask[i] = 1'b1;
         else
            vmask[vbit[i]] = 1'b1;
         idle(3);
         check({15'h0000, alert_req_ff}, 16'h0000);
         vmask = 8'h00;
         xmask = 3'h0;
         wr(8'h7A, 16'h0000);
         rd_chk(8'h7A, 16'h0001 << vbit[i]);
         wr(8'h7A, 16'h0001 << vbit[i]);
         rd_chk(8'h79, 16'h0000);
      end
      wr(8'h7A, 16'h0003);
      rd_chk(8'h7A, 16'h0000);
      det = 8'h09;
      idle(10);
      det = 8'h00;
      idle(8);
      rd_chk(8'h7A, 16'h00C0);
      pmbus_host_model_inst.clear_all();
      idle(3);
      rd_chk(8'h7A, 16'h0000);
      end_test("voltage flags");
      for (int i = 0; i < 10; i++) begin
         sumv[i] = 1'b1;
         idle(10);
         rd_chk(8'h79, 16'h0001 << sbit[i]);
         sumv[i] = 1'b0;
         idle(8);
      end
      rd_chk(8'h79, 16'h0000);
      end_test("summaries");
      busy_evt = 1'b1;
      unknown_evt = 1'b1;
      idle(1);
      busy_evt = 1'b0;
      unknown_evt = 1'b0;
      idle(3);
      rd_chk(8'h79, 16'h0081);
      check({15'h0000, alert_req_ff}, 16'h0001);
      bmask = 2'h3;
      idle(2);
      check({15'h0000, alert_req_ff}, 16'h0000);
      bmask = 2'h0;
      wr(8'h79, 16'hFFFF);
      rd_chk(8'h79, 16'h0081);
      wr(8'h79, 16'h0080);
      rd_chk(8'h79, 16'h0001);
      busy_evt = 1'b1;
      idle(1);
      busy_evt = 1'b0;
      wr(8'h79, 16'h0180);
      rd_chk(8'h79, 16'h0000);
      end_test("busy and unknown");
      pmbus_host_model_inst.xfer(1'b0, 8'h78, 16'h0000, q, ok, bad);
      check({14'h0000, ok, bad}, 16'h0001);
      check(q, 16'h0000);
      pmbus_host_model_inst.xfer(1'b1, 8'h78, 16'h0000, q, ok, bad);
      check({14'h0000, ok, bad}, 16'h0001);
      end_test("unmapped");
      finish_test();
   end
endmodule // testbench
